// ===== design/pecirq_pkg.sv
// constants shared by the pin edge change interrupt block
// assumes a 32-bit AXI4-Lite register bus and six port pins
package pecirq_pkg;
  // ==========================================
  // geometry
  localparam int NUM_PINS = 6;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int ARM_STAGES = 3;
  // ==========================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RISE_EN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FALL_EN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_CTL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
  // ==========================================
  // field positions
  localparam int CTL_SUMMARY_BIT = 0;
  localparam int CTL_MASTER_BIT = 1;
  localparam int STAT_EDGE_BIT = 0;
  // ==========================================
  // reset values
  localparam logic [NUM_PINS-1:0] RST_PINS = 6'h00;
  localparam logic RST_BIT = 1'b0;
  // ==========================================
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {PEC_RISE_EN, PEC_FALL_EN, PEC_FLAGS, PEC_INT_CTL,
    PEC_IRQ_STAT, PEC_IRQ_MASK, PEC_NONE} pec_reg_e;
endpackage

// ===== design/pecirq_top.sv
// pin edge change interrupt: edge detectors, per-pin flags, AXI4-Lite registers
// assumes pins are synchronous-safe after the internal two-flop synchroniser
`timescale 1ns/1ps
module pecirq_top
  import pecirq_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // port pins and power state
  input wire logic [pecirq_pkg::NUM_PINS-1:0] PINS,
  input wire logic SLEEP,
  output logic WAKE,
  output logic IRQ,
  // axi4-lite write address
  input wire logic [pecirq_pkg::ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [pecirq_pkg::ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import pecirq_pkg::*;

  function automatic pec_reg_e decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFS_RISE_EN: decode = PEC_RISE_EN;
      OFS_FALL_EN: decode = PEC_FALL_EN;
      OFS_FLAGS: decode = PEC_FLAGS;
      OFS_INT_CTL: decode = PEC_INT_CTL;
      OFS_IRQ_STAT: decode = PEC_IRQ_STAT;
      OFS_IRQ_MASK: decode = PEC_IRQ_MASK;
      default: decode = PEC_NONE;
    endcase
  endfunction

  logic [NUM_PINS-1:0] sync1_q, sync2_q, prev_q;
  logic [ARM_STAGES-1:0] arm_q;
  logic [NUM_PINS-1:0] rise_en_q, fall_en_q, flags_q, flags_d;
  logic [NUM_PINS-1:0] rise_hit, fall_hit, edge_set;
  logic master_q, stat_q, mask_q, wake_q;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic aw_take, w_take, wr_go, rd_take;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  pec_reg_e wr_reg;
  logic wr_lane;

  // ==========================================
  // pin synchroniser and edge detect
  // two-flop sync, then compare
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sync1_q <= RST_PINS;
      sync2_q <= RST_PINS;
      prev_q <= RST_PINS;
    end else begin
      sync1_q <= PINS;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // blocks false edges until prev holds a real sample after reset
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      arm_q <= '0;
    end else begin
      arm_q <= {arm_q[ARM_STAGES-2:0], 1'b1};
    end
  end

  assign rise_hit = (sync2_q & ~prev_q) & rise_en_q & {NUM_PINS{arm_q[ARM_STAGES-1]}};
  assign fall_hit = (~sync2_q & prev_q) & fall_en_q & {NUM_PINS{arm_q[ARM_STAGES-1]}};
  assign edge_set = rise_hit | fall_hit;

  // ==========================================
  // write channel
  assign AWREADY = !aw_held_q && !bvalid_q;
  assign WREADY = !w_held_q && !bvalid_q;
  assign aw_take = AWVALID && AWREADY;
  assign w_take = WVALID && WREADY;
  assign wr_go = (aw_held_q || aw_take) && (w_held_q || w_take);
  assign wr_addr = aw_held_q ? awaddr_q : AWADDR;
  assign wr_data = w_held_q ? wdata_q : WDATA;
  assign wr_strb = w_held_q ? wstrb_q : WSTRB;
  assign wr_reg = decode(wr_addr);
  // registers are one byte wide, so only lane 0 carries data
  assign wr_lane = wr_go && wr_strb[0];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_q <= 1'b1;
          awaddr_q <= AWADDR;
        end
        if (w_take) begin
          w_held_q <= 1'b1;
          wdata_q <= WDATA;
          wstrb_q <= WSTRB;
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_reg == PEC_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================
  // control registers
  // six enable bits each for rise and fall, one bit each for master and mask
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rise_en_q <= RST_PINS;
      fall_en_q <= RST_PINS;
      master_q <= RST_BIT;
      mask_q <= RST_BIT;
    end else if (wr_lane) begin
      if (wr_reg == PEC_RISE_EN) rise_en_q <= wr_data[NUM_PINS-1:0];
      if (wr_reg == PEC_FALL_EN) fall_en_q <= wr_data[NUM_PINS-1:0];
      if (wr_reg == PEC_INT_CTL) master_q <= wr_data[CTL_MASTER_BIT];
      if (wr_reg == PEC_IRQ_MASK) mask_q <= wr_data[STAT_EDGE_BIT];
    end
  end

  // ==========================================
  // per-pin flags
  // clear by zero, new edge wins
  always_comb begin
    flags_d = flags_q;
    if (wr_lane && wr_reg == PEC_FLAGS) flags_d = flags_q & wr_data[NUM_PINS-1:0];
    flags_d = flags_d | edge_set;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      flags_q <= RST_PINS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // sticky event bit, write one to clear; a coincident event wins
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      stat_q <= RST_BIT;
    end else if (|edge_set) begin
      stat_q <= 1'b1;
    end else if (wr_lane && wr_reg == PEC_IRQ_STAT && wr_data[STAT_EDGE_BIT]) begin
      stat_q <= 1'b0;
    end
  end

  // ==========================================
  // request and wake
  // request gated by master enable
  assign IRQ = master_q && stat_q && mask_q;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= SLEEP && master_q && (|edge_set);
    end
  end
  assign WAKE = wake_q;

  // ==========================================
  // read channel
  assign ARREADY = !rvalid_q;
  assign rd_take = ARVALID && ARREADY;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      unique case (decode(ARADDR))
        PEC_RISE_EN: rdata_q[NUM_PINS-1:0] <= rise_en_q;
        PEC_FALL_EN: rdata_q[NUM_PINS-1:0] <= fall_en_q;
        PEC_FLAGS: rdata_q[NUM_PINS-1:0] <= flags_q;
        PEC_INT_CTL: begin
          rdata_q[CTL_SUMMARY_BIT] <= |flags_q;
          rdata_q[CTL_MASTER_BIT] <= master_q;
        end
        PEC_IRQ_STAT: rdata_q[STAT_EDGE_BIT] <= stat_q;
        PEC_IRQ_MASK: rdata_q[STAT_EDGE_BIT] <= mask_q;
        PEC_NONE: rresp_q <= RESP_SLVERR;
      endcase
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  // ==========================================
  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence s_pin0_rise;
    !PINS[0] ##1 PINS[0] [*3];
  endsequence

  sequence s_flag0_seen;
    ##[1:3] flags_q[0];
  endsequence

  // a clearing write with no coincident edge
  sequence s_quiet_clear;
    wr_lane && wr_reg == PEC_FLAGS && !(|edge_set);
  endsequence

  a_rise_sets_flag: assert property (
    (|rise_hit) |=> ((flags_q & $past(rise_hit)) == $past(rise_hit)))
    else $error("rise edge missed");
  a_fall_sets_flag: assert property (
    (|fall_hit) |=> ((flags_q & $past(fall_hit)) == $past(fall_hit)))
    else $error("fall edge missed");
  a_both_edges_flag: assert property (
    (rise_en_q[1] && fall_en_q[1] && arm_q[ARM_STAGES-1] && (sync2_q[1] != prev_q[1]))
    |=> flags_q[1]) else $error("edge not flagged");
  a_no_master_irq: assert property (
    !master_q |-> !IRQ) else $error("irq without master");
  a_edge_raises_irq: assert property (
    ((|edge_set) && master_q && mask_q && !wr_lane) |=> IRQ)
    else $error("irq missing");
  a_stat_set_wins: assert property (
    (|edge_set) |=> stat_q) else $error("event lost in status");
  a_summary_reads: assert property (
    (rd_take && decode(ARADDR) == PEC_INT_CTL)
    |=> (rdata_q[CTL_SUMMARY_BIT] == (|$past(flags_q)))) else $error("summary wrong");
  a_clear_edge_wins: assert property (
    (wr_lane && wr_reg == PEC_FLAGS && (|edge_set))
    |=> ((flags_q & $past(edge_set)) == $past(edge_set))) else $error("edge lost in clear");
  a_zero_clears: assert property (
    s_quiet_clear |=> ((flags_q & ~$past(wr_data[NUM_PINS-1:0])) == '0))
    else $error("flag not cleared");
  a_flag_hw_only: assert property (
    ((flags_q & ~$past(flags_q) & ~$past(edge_set)) == '0))
    else $error("flag set without edge");
  a_sleep_wake: assert property (
    (SLEEP && master_q && (|edge_set)) |=> (WAKE && flags_q != '0))
    else $error("no wake");
  a_wake_gated: assert property (
    WAKE |-> ($past(SLEEP) && $past(master_q))) else $error("wake without sleep and master");
  a_upper_zero: assert property (
    RVALID |-> (RDATA[31:NUM_PINS] == '0)) else $error("upper bits set");
  a_sync_rise: assert property (
    (s_pin0_rise and (rise_en_q[0] && arm_q[ARM_STAGES-1]) [*4])
    |-> s_flag0_seen or ##0 flags_q[0]) else $error("sync edge missed");
endmodule // pecirq_top

// ===== tb/pecirq_pins.sv
// far side model: the six port pins
// assumes push-pull sources, no pull resistors
`timescale 1ns/1ps
module pecirq_pins (
  // clock
  input wire logic clk,
  // pin levels
  output logic [5:0] pins
);
  initial pins = 6'h00;
  // ==========================================
  // level change
  // change after an edge, then hold past the detector latency
  task automatic put(input logic [5:0] v);
    @(posedge clk);
    pins <= v;
    repeat (5) @(posedge clk);
  endtask
endmodule // pecirq_pins

// ===== tb/tb_top.sv
// self-checking bench for the pin edge change interrupt block
// assumes the pin model and a single 40 MHz clock
`timescale 1ns/1ps
module tb_top;
  import pecirq_pkg::*;
  logic CLOCK = 0;
  logic RST_N = 0;
  logic SLEEP = 0;
  logic AWVALID = 0;
  logic WVALID = 0;
  logic BREADY = 0;
  logic ARVALID = 0;
  logic RREADY = 0;
  logic [ADDR_W-1:0] AWADDR = 0;
  logic [ADDR_W-1:0] ARADDR = 0;
  logic [31:0] WDATA = 0;
  logic [3:0] WSTRB = 0;
  wire logic [NUM_PINS-1:0] PINS;
  logic WAKE, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  logic [33:0] exp_q[$];
  logic [5:0] r, f;
  int failures = 0;
  int check_count = 0;
  int wakes = 0;
  int cyc = 0;
  // ==========================================
  // instances
  pecirq_pins i_pins (.clk(CLOCK), .pins(PINS));
  pecirq_top i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .PINS(PINS), .SLEEP(SLEEP),
    .WAKE(WAKE), .IRQ(IRQ), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  initial begin
    forever #12.5 CLOCK = ~CLOCK;
  end
  // ==========================================
  // compare, report
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // bus master
  // each task starts one edge later, so no signal is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge CLOCK);
    exp_q.push_back({rsp, 32'h0});
    AWADDR <= a;
    AWVALID <= 1'b1;
    WDATA <= {24'h000000, d};
    WSTRB <= 4'hF;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w)) begin
      @(posedge CLOCK);
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    do @(posedge CLOCK); while (!BVALID);
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge CLOCK);
    exp_q.push_back(e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLOCK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLOCK); while (!RVALID);
    RREADY <= 1'b0;
  endtask
  // ==========================================
  // watcher: oldest note against each response
  always @(posedge CLOCK) begin
    cyc++;
    if (WAKE === 1'b1) wakes++;
    if (BVALID === 1'b1 && BREADY) chk({BRESP, 32'h0}, exp_q.pop_front());
    if (RVALID === 1'b1 && RREADY) chk({RRESP, RDATA}, exp_q.pop_front());
    if (cyc > 20000) begin
      failures++;
      summarize();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(93));
    repeat (5) @(posedge CLOCK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLOCK);
    rd(OFS_RISE_EN, 34'h0);
    rd(OFS_FALL_EN, 34'h0);
    rd(OFS_FLAGS, 34'h0);
    wr(OFS_RISE_EN, 8'hFF, RESP_OKAY);
    rd(OFS_RISE_EN, 34'h3F);
    wr(OFS_FALL_EN, 8'hFF, RESP_OKAY);
    rd(OFS_FALL_EN, 34'h3F);
    wr(8'h18, 8'hFF, RESP_SLVERR);
    rd(8'h18, {RESP_SLVERR, 32'h0});
    for (int k = 0; k < 6; k++) begin
      r = 6'($urandom);
      f = 6'($urandom);
      wr(OFS_RISE_EN, {2'b00, r}, RESP_OKAY);
      wr(OFS_FALL_EN, {2'b00, f}, RESP_OKAY);
      wr(OFS_FLAGS, 8'h00, RESP_OKAY);
      i_pins.put(6'h3F);
      rd(OFS_FLAGS, {28'h0, r});
      wr(OFS_FLAGS, 8'h00, RESP_OKAY);
      i_pins.put(6'h00);
      rd(OFS_FLAGS, {28'h0, f});
      rd(OFS_INT_CTL, {33'h0, |f});
      wr(OFS_FLAGS, 8'hFE, RESP_OKAY);
      rd(OFS_FLAGS, {28'h0, f & 6'h3E});
    end
    wr(OFS_RISE_EN, 8'h3F, RESP_OKAY);
    wr(OFS_FALL_EN, 8'h3F, RESP_OKAY);
    wr(OFS_FLAGS, 8'h00, RESP_OKAY);
    wr(OFS_IRQ_MASK, 8'h01, RESP_OKAY);
    wr(OFS_IRQ_STAT, 8'h01, RESP_OKAY);
    i_pins.put(6'h05);
    chk({33'h0, IRQ}, 34'h0);
    rd(OFS_FLAGS, 34'h05);
    wr(OFS_INT_CTL, 8'h02, RESP_OKAY);
    wr(OFS_IRQ_STAT, 8'h01, RESP_OKAY);
    wr(OFS_IRQ_MASK, 8'h00, RESP_OKAY);
    i_pins.put(6'h04);
    chk({33'h0, IRQ}, 34'h0);
    wr(OFS_IRQ_MASK, 8'h01, RESP_OKAY);
    chk({33'h0, IRQ}, 34'h1);
    rd(OFS_INT_CTL, 34'h3);
    wr(OFS_IRQ_STAT, 8'h01, RESP_OKAY);
    chk({33'h0, IRQ}, 34'h0);
    wr(OFS_FLAGS, 8'h00, RESP_OKAY);
    SLEEP <= 1'b1;
    wakes = 0;
    i_pins.put(6'h00);
    chk(34'(wakes), 34'h1);
    SLEEP <= 1'b0;
    rd(OFS_FLAGS, 34'h04);
    // clearing write taken in the very cycle that the rising edges set the flags
    fork
      i_pins.put(6'h3F);
      begin
        repeat (2) @(posedge CLOCK);
        wr(OFS_FLAGS, 8'h00, RESP_OKAY);
      end
    join
    rd(OFS_FLAGS, 34'h3F);
    summarize();
  end
endmodule // tb_top
